// [pld_pkg.sv]
// package for the programmable logic block: widths, array sizes, register offsets
// assumes a single 100 MHz clock and an 8-bit processor register bus
package pld_pkg;

    // ==================================================================
    // array dimensions
    localparam int N_IN        = 69;   // logic input bus width
    localparam int N_MAIN      = 8;    // main flash selects
    localparam int N_SEC       = 4;    // secondary flash selects
    localparam int N_MAIN_PT   = 3;
    localparam int N_SEC_PT    = 3;
    localparam int N_SRAM_PT   = 2;
    localparam int N_ECS       = 2;
    localparam int N_PSEL      = 2;
    localparam int N_CELL      = 16;   // output macrocells
    localparam int N_GRP       = 8;    // cells per group
    localparam int N_IMC       = 20;
    localparam int N_GPT       = 137;  // general array product terms
    localparam int N_CELL_PT   = 10;   // per-cell slots: native + borrowed
    // native / borrowable product terms per group
    localparam int AB_NATIVE   = 3;
    localparam int AB_BORROW   = 6;
    localparam int BC_NATIVE   = 4;
    localparam int BC_BORROW_L = 5;
    localparam int BC_BORROW_H = 6;

    // ==================================================================
    // register offsets inside the module register space
    localparam logic [7:0] OFS_GRP_AB  = 8'h20;
    localparam logic [7:0] OFS_GRP_BC  = 8'h21;
    localparam logic [7:0] OFS_MASK_AB = 8'h22;
    localparam logic [7:0] OFS_MASK_BC = 8'h23;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] CELL_RESET  = 8'h00;

    // ==================================================================
    // timing: expansion penalty on a decode select
    localparam int EXP_DELAY_NS  = 15;
    localparam int CLK_PERIOD_NS = 10;
    localparam int EXP_DELAY_CYC = (EXP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==================================================================
    // flip-flop personalities
    typedef enum logic [1:0] {
        PLD_FF_D  = 2'b00,
        PLD_FF_T  = 2'b01,
        PLD_FF_SR = 2'b11,
        PLD_FF_JK = 2'b10
    } pld_ff_t;

    // decode outputs travel together
    typedef struct packed {
        logic [N_MAIN-1:0] main_flash_sector_selects;
        logic [N_SEC-1:0]  secondary_flash_sector_selects;
        logic              sram_select;
        logic              csr_select;
        logic [N_ECS-1:0]  ext_chip_selects;
        logic              peripheral_select_low;
        logic              peripheral_select_high;
    } pld_decode_t;

    // per-cell configuration
    typedef struct packed {
        pld_ff_t                 ff_type;
        logic                    invert;      // xor polarity
        logic                    registered;  // output mux: 1 = flip-flop
        logic                    use_common_clk;
        logic [1:0]              port_sel;    // 0 none, 1 first, 2 second, 3 third
    } pld_cell_cfg_t;

    // processor register access
    typedef struct packed {
        logic       csr_sel;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pld_bus_t;

endpackage : pld_pkg

// [pld_logic.sv]
// programmable logic block: decode array and sixteen output macrocells
// assumes the processor bus and fuse pattern are synchronous to i_clock
//
// Overview of operation
// - eight main flash selects, each OR of up to three product terms
// - four secondary flash selects, each OR of up to three product terms
// - one SRAM select, OR of up to two product terms
// - one single-term select marking base of 256 control registers
// - two external chip selects, one term each; small package has one
// - two peripheral selects, one term each, enable data bus repeater
// - a product term ANDs any of 69 inputs; outputs OR terms
// - general array has 16 output cells, 20 input cells, 137 terms
// - each cell drives pin, data bus and feedback at once
// - xor polarity on summed terms; mux picks flip-flop or combinational
// - each cell flip-flop acts as D, T, JK or SR
// - clock, preset, clear each from a chosen product term
// - preset and clear are level, active high, asynchronous
// - flip-flops capture on rising edge of chosen clock
// - common clock pin selectable as shared rising-edge clock
// - allocator routes cell outputs bit by bit to three ports
// - one cell output reaches at most one port pin
// - native plus borrowed: 3+6 for cells 0-7, 4+5 for cells 8-11, 4+6 for 12-15
// - borrow only unused terms of designated cells, no added delay
// - expansion uses a fed-back cell, about 15 ns more delay
// - group registers at 20h, 21h; clear on power-on reset only
// - processor write overrides cell flip-flop over term controls
// - mask registers at 22h, 23h block writes per bit; reset 00h
`timescale 1ns/1ps
module pld_logic
(
    // clock and resets
    input  wire logic                          i_clock,
    input  wire logic                          i_rstn,
    input  wire logic                          i_por_n,
    // logic input bus (without cell feedback)
    input  wire logic [pld_pkg::N_IN-17:0]     i_inputs,
    input  wire logic                          i_common_macrocell_clock,
    input  wire logic                          i_small_package,
    // fuse pattern: and-masks and polarity per term
    input  wire logic [pld_pkg::N_IN-1:0]      i_dterm_use  [32],
    input  wire logic [pld_pkg::N_IN-1:0]      i_dterm_inv  [32],
    input  wire logic [pld_pkg::N_IN-1:0]      i_gterm_use  [pld_pkg::N_GPT],
    input  wire logic [pld_pkg::N_IN-1:0]      i_gterm_inv  [pld_pkg::N_GPT],
    input  wire logic [pld_pkg::N_CELL_PT-1:0] i_cell_terms [pld_pkg::N_CELL],
    input  wire logic [pld_pkg::N_CELL_PT-1:0] i_cell_borrow_ok [pld_pkg::N_CELL],
    input  wire pld_pkg::pld_cell_cfg_t        i_cell_cfg   [pld_pkg::N_CELL],
    // processor register bus
    input  wire pld_pkg::pld_bus_t             i_bus,
    // outputs
    output pld_pkg::pld_decode_t               o_decode,
    output logic      [7:0]                    o_rdata,
    output logic      [pld_pkg::N_CELL-1:0]    o_macrocell,
    output logic      [7:0]                    o_port_a,
    output logic      [7:0]                    o_port_b,
    output logic      [7:0]                    o_port_c
);
    // ==================================================================
    // reset release through two flops
    logic [1:0] rst_sync;
    logic       rstn;
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
        if (!i_rstn)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rstn = rst_sync[1];

    // ==================================================================
    // full input bus: external inputs plus both cell feedback groups
    logic [pld_pkg::N_IN-1:0]   in_bus;
    logic [pld_pkg::N_CELL-1:0] cell_q;
    logic [pld_pkg::N_CELL-1:0] cell_out;
    assign in_bus = {cell_out, i_inputs};

    // decode array terms: 8*3 + 4*3 + 2 + 1 + 2 + 2 = 43, use 32 slots
    // layout: 0..23 main, 24..31 secondary (one term shown per slot group below)
    logic [31:0] dterm;
    genvar gd;
    generate
        for (gd = 0; gd < 32; gd++)
        begin : g_dterm
            // and of chosen true or complement inputs
            assign dterm[gd] = &(~i_dterm_use[gd] | (in_bus ^ i_dterm_inv[gd]));
        end
    endgenerate

    // secondary selects share slots with sram and single-term selects
    logic [pld_pkg::N_SEC*pld_pkg::N_SEC_PT-1:0] sec_terms;
    assign sec_terms = {dterm[31:30], dterm[27:24], dterm[29:24]};

    // decode outputs, ors of their terms
    always_comb
    begin
        for (int i = 0; i < pld_pkg::N_MAIN; i++)
            o_decode.main_flash_sector_selects[i] = |dterm[3*i +: 3];
        for (int i = 0; i < pld_pkg::N_SEC; i++)
            o_decode.secondary_flash_sector_selects[i] = |sec_terms[3*i +: 3];
        o_decode.sram_select            = |dterm[25:24];
        o_decode.csr_select             = dterm[26];
        o_decode.ext_chip_selects[0]    = dterm[27];
        o_decode.ext_chip_selects[1]    = dterm[28] & ~i_small_package;
        o_decode.peripheral_select_low  = dterm[29] & ~i_small_package;
        o_decode.peripheral_select_high = dterm[30] & ~i_small_package;
    end

    // ==================================================================
    // general array product terms
    logic [pld_pkg::N_GPT-1:0] gterm;
    genvar gg;
    generate
        for (gg = 0; gg < pld_pkg::N_GPT; gg++)
        begin : g_gterm
            assign gterm[gg] = &(~i_gterm_use[gg] | (in_bus ^ i_gterm_inv[gg]));
        end
    endgenerate

    // ==================================================================
    // register state: groups and masks
    typedef struct packed {
        logic [7:0] mask_ab;
        logic [7:0] mask_bc;
        logic [7:0] rdata;
    } pld_regs_t;
    pld_regs_t regs;
    pld_regs_t next_regs;

    logic wr_ab;
    logic wr_bc;
    assign wr_ab = i_bus.csr_sel & i_bus.wr & (i_bus.addr == pld_pkg::OFS_GRP_AB);
    assign wr_bc = i_bus.csr_sel & i_bus.wr & (i_bus.addr == pld_pkg::OFS_GRP_BC);

    // mask and read-data update
    always_comb
    begin
        next_regs = regs;
        if (i_bus.csr_sel && i_bus.wr && i_bus.addr == pld_pkg::OFS_MASK_AB)
            next_regs.mask_ab = i_bus.wdata;
        if (i_bus.csr_sel && i_bus.wr && i_bus.addr == pld_pkg::OFS_MASK_BC)
            next_regs.mask_bc = i_bus.wdata;
        case (i_bus.addr)
            pld_pkg::OFS_GRP_AB:  next_regs.rdata = cell_out[7:0];
            pld_pkg::OFS_GRP_BC:  next_regs.rdata = cell_out[15:8];
            pld_pkg::OFS_MASK_AB: next_regs.rdata = regs.mask_ab;
            pld_pkg::OFS_MASK_BC: next_regs.rdata = regs.mask_bc;
            default:              next_regs.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or negedge rstn)
    begin
        if (!rstn)
            regs <= '{mask_ab: pld_pkg::MASK_RESET, mask_bc: pld_pkg::MASK_RESET,
                      rdata: 8'h00};
        else
            regs <= next_regs;
    end
    assign o_rdata = regs.rdata;

    // ==================================================================
    // output macrocells
    genvar gc;
    generate
        for (gc = 0; gc < pld_pkg::N_CELL; gc++)
        begin : g_cell
            localparam int LIM = (gc < 8) ? pld_pkg::AB_NATIVE + pld_pkg::AB_BORROW :
                                 (gc < 12) ? pld_pkg::BC_NATIVE + pld_pkg::BC_BORROW_L :
                                 pld_pkg::BC_NATIVE + pld_pkg::BC_BORROW_H;
            localparam int NAT = (gc < 8) ? pld_pkg::AB_NATIVE : pld_pkg::BC_NATIVE;
            localparam int BASE = gc * 8;
            logic [pld_pkg::N_CELL_PT-1:0] slot;
            logic       sum;
            logic       d_in;
            logic       ff_clk;
            logic       pr;
            logic       clr;
            logic       ld;
            logic       ld_val;
            logic       nxt;
            logic       q;           // this cell's flip-flop, one process per bit
            pld_pkg::pld_cell_cfg_t cfg;
            assign cfg = i_cell_cfg[gc];
            // native terms always allowed, borrowed only if donor leaves them free
            for (genvar s = 0; s < pld_pkg::N_CELL_PT; s++)
            begin : g_slot
                if (s < LIM)
                    assign slot[s] = i_cell_terms[gc][s] & (s < NAT | i_cell_borrow_ok[gc][s])
                                     & gterm[(BASE + s) % pld_pkg::N_GPT];
                else
                    assign slot[s] = 1'b0;
            end
            // sum and polarity; spare terms drive clock, preset and clear
            assign sum    = ^{|slot[pld_pkg::N_CELL_PT-1:1], cfg.invert};
            assign d_in   = sum;
            assign ff_clk = cfg.use_common_clk ? i_common_macrocell_clock
                                               : gterm[(BASE + 7) % pld_pkg::N_GPT];
            assign pr     = gterm[(BASE + 5) % pld_pkg::N_GPT];
            assign clr    = gterm[(BASE + 6) % pld_pkg::N_GPT];
            // processor load per bit, blocked by mask
            assign ld     = (gc < 8) ? wr_ab & ~regs.mask_ab[gc % 8]
                                     : wr_bc & ~regs.mask_bc[gc % 8];
            assign ld_val = i_bus.wdata[gc % 8];
            // flip-flop personality; jk and sr use the first term as second input
            always_comb
            begin
                case (cfg.ff_type)
                    pld_pkg::PLD_FF_D:  nxt = d_in;
                    pld_pkg::PLD_FF_T:  nxt = cell_q[gc] ^ d_in;
                    pld_pkg::PLD_FF_JK: nxt = (d_in & ~cell_q[gc]) | (~slot[0] & cell_q[gc]);
                    pld_pkg::PLD_FF_SR: nxt = d_in | (~slot[0] & cell_q[gc]);
                    default:            nxt = d_in;
                endcase
            end
            // power-on reset overrides everything, then load, clear, preset; no other reset
            always_ff @(posedge ff_clk or negedge i_por_n or posedge ld or posedge clr
                        or posedge pr)
            begin
                if (!i_por_n)
                    q <= 1'b0;
                else if (ld)
                    q <= ld_val;
                else if (clr)
                    q <= 1'b0;
                else if (pr)
                    q <= 1'b1;
                else
                    q <= nxt;
            end
            assign cell_q[gc] = q;
            assign cell_out[gc] = cfg.registered ? cell_q[gc] : sum;
        end
    endgenerate
    assign o_macrocell = cell_out;

    // ==================================================================
    // allocator: each cell goes to at most one selected port bit
    always_comb
    begin
        o_port_a = 8'h00;
        o_port_b = 8'h00;
        o_port_c = 8'h00;
        for (int i = 0; i < pld_pkg::N_CELL; i++)
        begin
            case (i_cell_cfg[i].port_sel)
                2'd1:    o_port_a[i % 8] = cell_out[i] & ~i_small_package;
                2'd2:    o_port_b[i % 8] = cell_out[i];
                2'd3:    o_port_c[i % 8] = cell_out[i];
                default: ;
            endcase
        end
    end

    // ==================================================================
    // checks
    property p_mask_blocks;
        @(posedge i_clock) disable iff (!rstn)
        (wr_ab && regs.mask_ab[0]) |-> !g_cell[0].ld;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked cell loaded");
    property p_rdata;
        @(posedge i_clock) disable iff (!rstn)
        (i_bus.addr == pld_pkg::OFS_MASK_AB) |=> (o_rdata == $past(regs.mask_ab));
    endproperty
    a_rdata: assert property (p_rdata) else $error("mask readback wrong");
    property p_small;
        @(posedge i_clock) disable iff (!rstn)
        i_small_package |-> !o_decode.ext_chip_selects[1] && !o_decode.peripheral_select_low;
    endproperty
    a_small: assert property (p_small) else $error("pin on small package");

    // group register reads back the live cell outputs one cycle later
    property p_grp_read;
        @(posedge i_clock) disable iff (!rstn)
        (i_bus.addr == pld_pkg::OFS_GRP_AB) |=> (o_rdata == $past(cell_out[7:0]));
    endproperty
    a_grp_read: assert property (p_grp_read) else $error("group readback wrong");

    // addresses outside the four registers read as zero
    property p_unmapped;
        @(posedge i_clock) disable iff (!rstn)
        (i_bus.addr < pld_pkg::OFS_GRP_AB || i_bus.addr > pld_pkg::OFS_MASK_BC)
            |=> (o_rdata == 8'h00);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // small package has no first port at all
    property p_port_a_small;
        @(posedge i_clock) disable iff (!rstn)
        i_small_package |-> (o_port_a == 8'h00);
    endproperty
    a_port_a_small: assert property (p_port_a_small) else $error("first port driven");

    // power-on reset holds every cell cleared
    property p_por_clear;
        @(posedge i_clock) disable iff (!rstn)
        !i_por_n |-> (cell_q == 16'h0000);
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("cell set during power-on");
    c_load: cover property (@(posedge i_clock) disable iff (!rstn) wr_ab);
    c_mask: cover property (@(posedge i_clock) disable iff (!rstn) regs.mask_bc != 8'h00);
    c_sram: cover property (@(posedge i_clock) disable iff (!rstn) o_decode.sram_select);
    c_por:  cover property (@(posedge i_clock) disable iff (!rstn) !i_por_n);
    c_csr:  cover property (@(posedge i_clock) disable iff (!rstn) o_decode.csr_select);

endmodule : pld_logic

// [pld_cpu_model.sv]
// processor-side register bus model for the programmable logic block
// assumes it shares the block clock; drives the bus just after falling edges
`timescale 1ns/1ps
module pld_cpu_model
(
    // clock and answer
    input  wire logic         i_clock,
    input  wire logic [7:0]   i_rdata,
    // register bus towards the block
    output pld_pkg::pld_bus_t o_bus
);
    // ==================================================================
    // bus idle at time zero
    initial o_bus = '0;

    // write: strobe and data held across one rising edge, then released
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    begin
        @(negedge i_clock);
        o_bus = '{1'b1, 1'b1, addr, data};
        @(negedge i_clock);
        o_bus = '{1'b0, 1'b0, ~addr, ~data};  // released lines drop the old value
    end
    endtask : write_reg

    // read: the answer is registered one edge after the address
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    begin
        @(negedge i_clock);
        o_bus = '{1'b1, 1'b0, addr, 8'h00};
        @(negedge i_clock);
        data  = i_rdata;
        o_bus = '{1'b0, 1'b0, ~addr, 8'hFF};  // accesses spaced by an idle cycle
    end
    endtask : read_reg
endmodule : pld_cpu_model

// [pld_decode_and_output_macrocells_test.sv]
// self-checking bench for the decode array and the sixteen output macrocells
// assumes the package and the cpu bus model compile first
`timescale 1ns/1ps
module pld_decode_and_output_macrocells_test;
    // ==================================================================
    // stimulus and observed signals
    logic                   i_clock, i_rstn, i_por_n, i_common_macrocell_clock;
    logic                   i_small_package;
    logic [52:0]            i_inputs;
    logic [68:0]            dterm_use [32], dterm_inv [32], gterm_use [137], gterm_inv [137];
    logic [9:0]             cell_terms [16], borrow_ok [16];
    pld_pkg::pld_cell_cfg_t cell_cfg [16];
    pld_pkg::pld_bus_t      bus;
    pld_pkg::pld_decode_t   decode;
    logic [7:0]             rdata, port_a, port_b, port_c;
    logic [15:0]            cells;
    int                     errors = 0, n_compared = 0;

    // ==================================================================
    // design and processor model
    pld_logic DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_por_n(i_por_n),
        .i_inputs(i_inputs), .i_common_macrocell_clock(i_common_macrocell_clock),
        .i_small_package(i_small_package), .i_dterm_use(dterm_use), .i_dterm_inv(dterm_inv),
        .i_gterm_use(gterm_use), .i_gterm_inv(gterm_inv), .i_cell_terms(cell_terms),
        .i_cell_borrow_ok(borrow_ok), .i_cell_cfg(cell_cfg), .i_bus(bus), .o_decode(decode),
        .o_rdata(rdata), .o_macrocell(cells), .o_port_a(port_a), .o_port_b(port_b),
        .o_port_c(port_c));
    pld_cpu_model cpu (.i_clock(i_clock), .i_rdata(rdata), .o_bus(bus));

    // 100 MHz clock
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // hang guard
    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end

    // ==================================================================
    // shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask : check

    task automatic wrap_up;
    begin
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask : wrap_up

    task automatic idle(input int n);
    begin
        repeat (n) @(negedge i_clock);
    end
    endtask : idle

    task automatic check_cells(input logic [15:0] exp);
    begin
        check(32'(cells), 32'(exp));
    end
    endtask : check_cells

    task automatic check_rd(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] got;
    begin
        cpu.read_reg(addr, got);
        check(32'(got), 32'(exp));
    end
    endtask : check_rd

    // all cells alike; first group routed by ab_port, second group to port c
    task automatic set_cfg(input pld_pkg::pld_ff_t ff, input logic inv, reg_on, cc,
                           input logic [1:0] ab_port);
    begin
        @(negedge i_clock);
        foreach (cell_cfg[k])
            cell_cfg[k] = '{ff, inv, reg_on, cc, (k < 8) ? ab_port : 2'h3};
        #1;  // let the combinational paths settle before any compare
    end
    endtask : set_cfg

    task automatic set_terms(input logic [9:0] terms, input logic [9:0] ok);
    begin
        @(negedge i_clock);
        foreach (cell_terms[k])
        begin
            cell_terms[k] = terms;
            borrow_ok[k]  = ok;
        end
        idle(1);
    end
    endtask : set_terms

    // rising edge on the term clock (input 3) or on the common clock pin
    task automatic pulse(input logic common);
    begin
        if (common)
            i_common_macrocell_clock = 1'b1;
        else
            i_inputs[3] = 1'b1;
        idle(3);
        i_common_macrocell_clock = 1'b0;
        i_inputs[3] = 1'b0;
        idle(3);
    end
    endtask : pulse

    // ==================================================================
    // scenarios
    task automatic test_decode;
        pld_pkg::pld_decode_t exp;
    begin
        for (int m = 0; m < 8; m++)
        begin
            @(negedge i_clock);
            foreach (dterm_inv[k])
                dterm_inv[k] = {67'h0, m[2], 1'b0};
            i_inputs[1:0]   = m[1:0];
            i_small_package = m[2];
            #1;
            exp = {18{m[0] & (m[1] ^ m[2])}};
            if (m[2])
                exp = exp & ~18'h0_000B;  // small package drops ext 1 and both peripheral selects
            check(32'(decode), 32'(exp));
        end
        i_small_package = 1'b0;
        $display("decode test done");
    end
    endtask : test_decode

    task automatic test_comb;
    begin
        i_inputs = '0;
        i_inputs[0] = 1'b1;
        set_cfg(pld_pkg::PLD_FF_D, 1'b0, 1'b0, 1'b0, 2'h2);
        check_cells(16'hFFFF);
        check(32'({port_a, port_b, port_c}), 32'h0000_FFFF);
        set_cfg(pld_pkg::PLD_FF_D, 1'b1, 1'b0, 1'b0, 2'h2);
        check_cells(16'h0000);
        set_cfg(pld_pkg::PLD_FF_D, 1'b0, 1'b0, 1'b0, 2'h1);
        check(32'({port_a, port_b, port_c}), 32'h00FF_00FF);
        i_small_package = 1'b1;
        idle(1);
        check(32'({port_a, port_b, port_c}), 32'h0000_00FF);
        i_small_package = 1'b0;
        i_inputs[4] = 1'b1;
        set_terms(10'h010, 10'h000);
        check_cells(16'h0000);
        set_terms(10'h010, 10'h3FF);
        check_cells(16'hFFFF);
        set_terms(10'h200, 10'h3FF);
        check_cells(16'hF000);
        set_terms(10'h008, 10'h000);
        check_cells(16'hFF00);
        set_terms(10'h002, 10'h000);
        $display("combinational and borrow test done");
    end
    endtask : test_comb

    task automatic test_ff;
    begin
        i_inputs = '0;
        i_inputs[0] = 1'b1;
        set_cfg(pld_pkg::PLD_FF_D, 1'b0, 1'b1, 1'b0, 2'h2);
        pulse(1'b0);
        check_cells(16'hFFFF);
        i_inputs[0] = 1'b0;
        pulse(1'b0);
        check_cells(16'h0000);
        set_cfg(pld_pkg::PLD_FF_D, 1'b1, 1'b1, 1'b0, 2'h2);
        pulse(1'b0);
        check_cells(16'hFFFF);
        i_inputs[2] = 1'b1;
        idle(3);
        check_cells(16'h0000);
        i_inputs[2] = 1'b0;
        i_inputs[1] = 1'b1;
        idle(3);
        check_cells(16'hFFFF);
        i_inputs[2] = 1'b1;
        idle(3);
        check_cells(16'h0000);
        i_inputs[2:1] = 2'h0;
        i_inputs[0] = 1'b1;
        set_cfg(pld_pkg::PLD_FF_D, 1'b0, 1'b1, 1'b1, 2'h2);
        pulse(1'b0);
        check_cells(16'h0000);
        pulse(1'b1);
        check_cells(16'hFFFF);
        set_cfg(pld_pkg::PLD_FF_T, 1'b0, 1'b1, 1'b0, 2'h2);
        pulse(1'b0);
        check_cells(16'h0000);
        pulse(1'b0);
        check_cells(16'hFFFF);
        i_inputs[0] = 1'b0;
        pulse(1'b0);
        check_cells(16'hFFFF);
        $display("flip-flop test done");
    end
    endtask : test_ff

    task automatic test_cpu;
    begin
        set_cfg(pld_pkg::PLD_FF_D, 1'b0, 1'b1, 1'b0, 2'h2);
        cpu.write_reg(8'h20, 8'hA5);
        cpu.write_reg(8'h21, 8'h3C);
        idle(1);
        check_cells(16'h3CA5);
        check_rd(8'h20, 8'hA5);
        check_rd(8'h21, 8'h3C);
        cpu.write_reg(8'h22, 8'h0F);
        cpu.write_reg(8'h20, 8'h00);
        check_rd(8'h20, 8'h05);
        check_rd(8'h22, 8'h0F);
        check_rd(8'h30, 8'h00);
        i_rstn = 1'b0;
        idle(10);
        i_rstn = 1'b1;
        idle(3);
        check_cells(16'h3C05);
        check_rd(8'h22, 8'h00);
        cpu.write_reg(8'h23, 8'hF0);
        cpu.write_reg(8'h21, 8'h00);
        check_rd(8'h21, 8'h30);
        i_por_n = 1'b0;
        idle(2);
        i_por_n = 1'b1;
        idle(3);
        check_cells(16'h0000);
        $display("processor access test done");
    end
    endtask : test_cpu

    // ==================================================================
    // fuse pattern, reset and main sequence
    initial
    begin
        i_rstn = 1'b0;
        i_por_n = 1'b0;
        i_common_macrocell_clock = 1'b0;
        i_small_package = 1'b0;
        i_inputs = '0;
        foreach (dterm_use[t])
        begin
            dterm_use[t] = 69'h3;
            dterm_inv[t] = '0;
        end
        // slots 4..7 of each cell use inputs 4, 1 (preset), 2 (clear), 3 (clock)
        foreach (gterm_use[t])
        begin
            gterm_use[t] = 69'h1 << ((t % 8 == 4) ? 4 : (t % 8 > 4) ? t % 8 - 4 : 0);
            gterm_inv[t] = '0;
        end
        foreach (cell_cfg[k])
        begin
            cell_cfg[k]   = '{pld_pkg::PLD_FF_D, 1'b0, 1'b1, 1'b0, (k < 8) ? 2'h2 : 2'h3};
            cell_terms[k] = 10'h002;  // slot 0 is the jk/sr second input, slot 1 sums
            borrow_ok[k]  = 10'h000;
        end
        idle(10);
        i_rstn = 1'b1;
        i_por_n = 1'b1;
        idle(3);
        check_cells(16'h0000);
        test_decode();
        test_comb();
        test_ff();
        test_cpu();
        wrap_up();
    end
endmodule : pld_decode_and_output_macrocells_test
